// *** common/threshold_counter_pkg.sv ***
// Constants and carrier types shared by the threshold counter design
`default_nettype none

package threshold_counter_pkg;

  // ----------------------------------------------------------------
  // Count range and widths
  // ----------------------------------------------------------------
  localparam int unsigned        COUNT_W     = 20;
  localparam logic [COUNT_W-1:0] COUNT_MAX   = 20'hF423F;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 20'h00000;
  localparam int unsigned        BLOCK_W     = 8;
  localparam int unsigned        REF_W       = 32;
  localparam int unsigned        ADDR_W      = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_OFS         = 8'h00;
  localparam logic [ADDR_W-1:0] SET_THRESH_OFS   = 8'h04;
  localparam logic [ADDR_W-1:0] CLEAR_THRESH_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] SET_BLOCK_OFS    = 8'h0C;
  localparam logic [ADDR_W-1:0] CLEAR_BLOCK_OFS  = 8'h10;
  localparam logic [ADDR_W-1:0] COUNT_OFS        = 8'h14;
  localparam logic [ADDR_W-1:0] STATUS_OFS       = 8'h18;
  localparam logic [ADDR_W-1:0] SET_ACTIVE_OFS   = 8'h1C;
  localparam logic [ADDR_W-1:0] CLEAR_ACTIVE_OFS = 8'h20;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned        CTRL_RETAIN_BIT    = 0;
  localparam int unsigned        CTRL_SET_REF_BIT   = 1;
  localparam int unsigned        CTRL_CLEAR_REF_BIT = 2;
  localparam int unsigned        STAT_SWITCH_BIT    = 0;
  localparam int unsigned        STAT_CLEAR_BIT     = 1;
  localparam int unsigned        STAT_FAIL_BIT      = 2;
  localparam logic [2:0]         CTRL_RESET         = 3'h0;
  localparam logic [COUNT_W-1:0] SET_THRESH_RESET   = 20'h00000;
  localparam logic [COUNT_W-1:0] CLEAR_THRESH_RESET = 20'h00000;
  localparam logic [BLOCK_W-1:0] BLOCK_RESET        = 8'h00;
  localparam logic [1:0]         RESP_OKAY          = 2'h0;
  localparam logic [1:0]         RESP_SLVERR        = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS        = 20;
  localparam int unsigned PROGRAM_CYCLE_NS     = 10000;
  localparam int unsigned PROGRAM_CYCLE_CYCLES = (PROGRAM_CYCLE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                                 PROGRAM_CYCLE_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Bus carriers and state encodings
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axil_rsp_t;

  typedef enum logic [0:0] {WR_IDLE = 1'b0, WR_RESP = 1'b1} wr_state_t;
  typedef enum logic [0:0] {RD_IDLE = 1'b0, RD_DATA = 1'b1} rd_state_t;

endpackage

`default_nettype wire

// *** rtl/program_cycle_tick.sv ***
// Divider that marks the start of each program cycle with a one-cycle pulse
`default_nettype none

module program_cycle_tick
  import threshold_counter_pkg::*;
#(
  parameter int unsigned PERIOD = PROGRAM_CYCLE_CYCLES
)
(
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      tick
);

  // Width limits the period to 65536 clocks
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } tick_state_t;

  tick_state_t state_reg;
  tick_state_t state_next;

  always_comb
  begin
    state_next      = state_reg;
    state_next.tick = 1'b0;
    if (state_reg.cnt == 16'(PERIOD - 1))
    begin
      state_next.cnt  = 16'h0000;
      state_next.tick = 1'b1;
    end
    else
    begin
      state_next.cnt = state_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign tick = state_reg.tick;

endmodule // program_cycle_tick

`default_nettype wire

// *** rtl/threshold_source.sv ***
// Picks a threshold from a constant or another block's value and clamps it
`default_nettype none

module threshold_source
  import threshold_counter_pkg::*;
#(
  parameter int unsigned NUM_REFS = 8
)
(
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic                           use_ref,
  input  wire logic [COUNT_W-1:0]             const_val,
  input  wire logic [BLOCK_W-1:0]             block_no,
  input  wire logic [NUM_REFS-1:0][REF_W-1:0] ref_values,
  output logic      [COUNT_W-1:0]             thresh
);

  typedef struct packed {
    logic [COUNT_W-1:0] thresh;
  } src_state_t;

  src_state_t        state_reg;
  src_state_t        state_next;
  logic [REF_W-1:0]  picked;

  always_comb
  begin
    picked = REF_W'(const_val);
    if (use_ref)
    begin
      // Unknown block numbers yield zero
      picked = '0;
      for (int i = 0; i < NUM_REFS; i++)
        if (block_no == BLOCK_W'(i))
          picked = ref_values[i];
    end
    state_next = state_reg;
    if (picked[REF_W-1])
      state_next.thresh = COUNT_RESET; // see RL11
    else if (picked > REF_W'(COUNT_MAX))
      state_next.thresh = COUNT_MAX; // see RL11
    else
      state_next.thresh = picked[COUNT_W-1:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign thresh = state_reg.thresh;

endmodule // threshold_source

`default_nettype wire

// *** rtl/up_down_threshold_counter.sv ***
// Up/down pulse counter with two-threshold switch output and AXI4-Lite registers
//
// Summary of operation
// RL1 - Only rising edges of the pulse input count; falling edges never do.
// RL2 - Sense input low counts up, sense input high counts down.
// RL3 - Each accepted rising edge moves the count by exactly one.
// RL4 - The clear input sets the count to zero.
// RL5 - While clear is high the switch is low and pulses are ignored.
// RL6 - Set above clear: on at count >= set, off below clear, else hold.
// RL7 - Set below clear: on only while count is strictly between them.
// RL8 - Power loss clears count and switch unless retention is selected.
// RL9 - Thresholds are compared once per program cycle.
// RL10 - Either threshold may come from another block's value, chosen by number.
// RL11 - Referenced threshold values are clamped into 0 to 999999.
// RL12 - The count saturates at 0 and 999999, never wrapping.
`default_nettype none

module up_down_threshold_counter
  import threshold_counter_pkg::*;
#(
  parameter int unsigned NUM_REFS     = 8,
  parameter int unsigned CYCLE_CLOCKS = PROGRAM_CYCLE_CYCLES
)
(
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire axil_req_t                      s_axil_req,
  output axil_rsp_t                           s_axil_rsp,
  input  wire logic                           count_pulse,
  input  wire logic                           count_sense,
  input  wire logic                           count_clear,
  input  wire logic                           power_fail,
  input  wire logic [NUM_REFS-1:0][REF_W-1:0] ref_values,
  output logic                                switch_out,
  output logic      [COUNT_W-1:0]             count_value
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]         pulse_sync;
    logic [1:0]         sense_sync;
    logic [1:0]         clear_sync;
    logic [1:0]         fail_sync;
    logic [COUNT_W-1:0] count;
    logic               sw;
    logic [2:0]         ctrl;
    logic [COUNT_W-1:0] set_const;
    logic [COUNT_W-1:0] clear_const;
    logic [BLOCK_W-1:0] set_block;
    logic [BLOCK_W-1:0] clear_block;
    wr_state_t          wr_state;
    logic               aw_held;
    logic               w_held;
    logic [ADDR_W-1:0]  wr_addr;
    logic [31:0]        wr_data;
    logic [3:0]         wr_strb;
    rd_state_t          rd_state;
    axil_rsp_t          rsp;
  } ctr_state_t;

  ctr_state_t         state_reg;
  ctr_state_t         state_next;
  logic               cycle_tick;
  logic [COUNT_W-1:0] set_thresh;
  logic [COUNT_W-1:0] clear_thresh;
  logic               pulse_rise;
  logic [31:0]        rd_word;
  logic               rd_ok;

  // ----------------------------------------------------------------
  // Program cycle and threshold sources
  // ----------------------------------------------------------------
  program_cycle_tick #(
    .PERIOD (CYCLE_CLOCKS)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (cycle_tick)
  );

  // Each threshold is a constant or a referenced block value; see RL10
  threshold_source #(
    .NUM_REFS (NUM_REFS)
  ) u_set_src (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .use_ref    (state_reg.ctrl[CTRL_SET_REF_BIT]),
    .const_val  (state_reg.set_const),
    .block_no   (state_reg.set_block),
    .ref_values (ref_values),
    .thresh     (set_thresh)
  );

  threshold_source #(
    .NUM_REFS (NUM_REFS)
  ) u_clear_src (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .use_ref    (state_reg.ctrl[CTRL_CLEAR_REF_BIT]),
    .const_val  (state_reg.clear_const),
    .block_no   (state_reg.clear_block),
    .ref_values (ref_values),
    .thresh     (clear_thresh)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_word;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        res[8*b +: 8] = new_word[8*b +: 8];
    return res;
  endfunction

  function automatic logic same_word(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] ofs
  );
    return a[ADDR_W-1:2] == ofs[ADDR_W-1:2];
  endfunction

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_word = 32'h00000000;
    rd_ok   = 1'b1;
    if (same_word(s_axil_req.araddr, CTRL_OFS))
      rd_word = 32'(state_reg.ctrl);
    else if (same_word(s_axil_req.araddr, SET_THRESH_OFS))
      rd_word = 32'(state_reg.set_const);
    else if (same_word(s_axil_req.araddr, CLEAR_THRESH_OFS))
      rd_word = 32'(state_reg.clear_const);
    else if (same_word(s_axil_req.araddr, SET_BLOCK_OFS))
      rd_word = 32'(state_reg.set_block);
    else if (same_word(s_axil_req.araddr, CLEAR_BLOCK_OFS))
      rd_word = 32'(state_reg.clear_block);
    else if (same_word(s_axil_req.araddr, COUNT_OFS))
      rd_word = 32'(state_reg.count);
    else if (same_word(s_axil_req.araddr, STATUS_OFS))
    begin
      rd_word[STAT_SWITCH_BIT] = state_reg.sw;
      rd_word[STAT_CLEAR_BIT]  = state_reg.clear_sync[1];
      rd_word[STAT_FAIL_BIT]   = state_reg.fail_sync[1];
    end
    else if (same_word(s_axil_req.araddr, SET_ACTIVE_OFS))
      rd_word = 32'(set_thresh);
    else if (same_word(s_axil_req.araddr, CLEAR_ACTIVE_OFS))
      rd_word = 32'(clear_thresh);
    else
      rd_ok = 1'b0;
  end

  assign pulse_rise = state_reg.pulse_sync[1] & ~state_reg.pulse_sync[2];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;

    // Pins come from outside the clock domain
    state_next.pulse_sync = {state_reg.pulse_sync[1:0], count_pulse};
    state_next.sense_sync = {state_reg.sense_sync[0], count_sense};
    state_next.clear_sync = {state_reg.clear_sync[0], count_clear};
    state_next.fail_sync  = {state_reg.fail_sync[0], power_fail};

    if (state_reg.clear_sync[1])
    begin
      state_next.count = COUNT_RESET; // see RL4
      state_next.sw    = 1'b0; // see RL5
    end
    else if (state_reg.fail_sync[1])
    begin
      // Pulses seen while supply is failing are not trusted
      if (!state_reg.ctrl[CTRL_RETAIN_BIT])
      begin
        state_next.count = COUNT_RESET; // see RL8
        state_next.sw    = 1'b0; // see RL8
      end
    end
    else
    begin
      if (pulse_rise) // see RL1
      begin
        if (!state_reg.sense_sync[1]) // see RL2
        begin
          if (state_reg.count != COUNT_MAX) // see RL12
            state_next.count = state_reg.count + 20'h00001; // see RL3
        end
        else if (state_reg.count != COUNT_RESET) // see RL12
        begin
          state_next.count = state_reg.count - 20'h00001; // see RL3
        end
      end
      // Output may lag the count by up to one program cycle
      if (cycle_tick) // see RL9
      begin
        if (set_thresh > clear_thresh)
        begin
          if (state_reg.count >= set_thresh)
            state_next.sw = 1'b1; // see RL6
          else if (state_reg.count < clear_thresh)
            state_next.sw = 1'b0; // see RL6
        end
        else
        begin
          // Equal thresholds leave an empty window, so the output stays low
          state_next.sw = (state_reg.count > set_thresh) &&
                          (state_reg.count < clear_thresh); // see RL7
        end
      end
    end

    // --------------------------------------------------------------
    // Write channel: address and data taken in either order
    // --------------------------------------------------------------
    if (s_axil_req.awvalid && state_reg.rsp.awready)
    begin
      state_next.aw_held = 1'b1;
      state_next.wr_addr = s_axil_req.awaddr;
    end
    if (s_axil_req.wvalid && state_reg.rsp.wready)
    begin
      state_next.w_held  = 1'b1;
      state_next.wr_data = s_axil_req.wdata;
      state_next.wr_strb = s_axil_req.wstrb;
    end

    case (state_reg.wr_state)
      WR_IDLE:
      begin
        if (state_next.aw_held && state_next.w_held)
        begin
          state_next.aw_held    = 1'b0;
          state_next.w_held     = 1'b0;
          state_next.rsp.bvalid = 1'b1;
          state_next.rsp.bresp  = RESP_OKAY;
          state_next.wr_state   = WR_RESP;
          if (same_word(state_next.wr_addr, CTRL_OFS))
            state_next.ctrl = 3'(merge_bytes(32'(state_reg.ctrl),
                                             state_next.wr_data, state_next.wr_strb));
          else if (same_word(state_next.wr_addr, SET_THRESH_OFS))
            state_next.set_const = COUNT_W'(merge_bytes(32'(state_reg.set_const),
                                                        state_next.wr_data, state_next.wr_strb));
          else if (same_word(state_next.wr_addr, CLEAR_THRESH_OFS))
            state_next.clear_const = COUNT_W'(merge_bytes(32'(state_reg.clear_const),
                                                          state_next.wr_data, state_next.wr_strb));
          else if (same_word(state_next.wr_addr, SET_BLOCK_OFS))
            state_next.set_block = BLOCK_W'(merge_bytes(32'(state_reg.set_block),
                                                        state_next.wr_data, state_next.wr_strb));
          else if (same_word(state_next.wr_addr, CLEAR_BLOCK_OFS))
            state_next.clear_block = BLOCK_W'(merge_bytes(32'(state_reg.clear_block),
                                                          state_next.wr_data, state_next.wr_strb));
          else if (!same_word(state_next.wr_addr, COUNT_OFS) &&
                   !same_word(state_next.wr_addr, STATUS_OFS) &&
                   !same_word(state_next.wr_addr, SET_ACTIVE_OFS) &&
                   !same_word(state_next.wr_addr, CLEAR_ACTIVE_OFS))
            state_next.rsp.bresp = RESP_SLVERR;
        end
      end
      WR_RESP:
      begin
        if (s_axil_req.bready)
        begin
          state_next.rsp.bvalid = 1'b0;
          state_next.wr_state   = WR_IDLE;
        end
      end
      default:
      begin
        state_next.wr_state = WR_IDLE;
      end
    endcase

    state_next.rsp.awready = (state_next.wr_state == WR_IDLE) && !state_next.aw_held;
    state_next.rsp.wready  = (state_next.wr_state == WR_IDLE) && !state_next.w_held;

    // --------------------------------------------------------------
    // Read channel
    // --------------------------------------------------------------
    case (state_reg.rd_state)
      RD_IDLE:
      begin
        if (s_axil_req.arvalid && state_reg.rsp.arready)
        begin
          state_next.rsp.rdata  = rd_word;
          state_next.rsp.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
          state_next.rsp.rvalid = 1'b1;
          state_next.rd_state   = RD_DATA;
        end
      end
      RD_DATA:
      begin
        if (s_axil_req.rready)
        begin
          state_next.rsp.rvalid = 1'b0;
          state_next.rd_state   = RD_IDLE;
        end
      end
      default:
      begin
        state_next.rd_state = RD_IDLE;
      end
    endcase

    state_next.rsp.arready = (state_next.rd_state == RD_IDLE);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg             <= '0;
      state_reg.count       <= COUNT_RESET;
      state_reg.ctrl        <= CTRL_RESET;
      state_reg.set_const   <= SET_THRESH_RESET;
      state_reg.clear_const <= CLEAR_THRESH_RESET;
      state_reg.set_block   <= BLOCK_RESET;
      state_reg.clear_block <= BLOCK_RESET;
      state_reg.wr_state    <= WR_IDLE;
      state_reg.rd_state    <= RD_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign s_axil_rsp  = state_reg.rsp;
  assign switch_out  = state_reg.sw;
  assign count_value = state_reg.count;

endmodule // up_down_threshold_counter

`default_nettype wire

// *** tb/pulse_source_model.sv ***
// Digital input model that delivers count pulses
`default_nettype none

module pulse_source_model
(
  input  wire logic aclk,
  output logic      count_pulse
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle low between bursts, as a released input would be
  initial count_pulse = 1'b0;

  // Each level held at least two clocks so every rise stays distinct
  task automatic burst(input int n, input int hi, input int lo);
    repeat (n)
    begin
      @(posedge aclk);
      count_pulse <= 1'b1;
      repeat (hi) @(posedge aclk);
      count_pulse <= 1'b0;
      repeat (lo) @(posedge aclk);
    end
  endtask
endmodule // pulse_source_model

`default_nettype wire

// *** tb/up_down_threshold_counter_checker.sv ***
// Concurrent checks on the threshold counter ports
`default_nettype none

module up_down_threshold_counter_checker
  import threshold_counter_pkg::*;
#(
  parameter int unsigned NUM_REFS     = 8,
  parameter int unsigned CYCLE_CLOCKS = PROGRAM_CYCLE_CYCLES
)
(
  input wire logic                           aclk,
  input wire logic                           aresetn,
  input wire axil_req_t                      s_axil_req,
  input wire axil_rsp_t                      s_axil_rsp,
  input wire logic                           count_pulse,
  input wire logic                           count_sense,
  input wire logic                           count_clear,
  input wire logic                           power_fail,
  input wire logic [NUM_REFS-1:0][REF_W-1:0] ref_values,
  input wire logic                           switch_out,
  input wire logic [COUNT_W-1:0]             count_value
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----
  // Pins
  // ----
  chk_clear_zero: assert property (count_clear [*6] |-> count_value == COUNT_RESET)
    else $error("count not cleared");
  chk_clear_low: assert property (count_clear [*6] |-> !switch_out)
    else $error("switch high under clear");
  chk_step_one: assert property ($changed(count_value) && count_value != COUNT_RESET |->
    count_value == $past(count_value) + 20'h00001 || count_value == $past(count_value) - 20'h00001)
    else $error("count moved by more than one");
  // Pin sampled three edges before the new count carries both the rise and the direction
  chk_rise_dir: assert property (count_value > $past(count_value) |-> !$past(count_sense, 3) &&
    $past(count_pulse, 3) && !$past(count_pulse, 4))
    else $error("count rose without rise or while down");
  chk_count_max: assert property (count_value <= COUNT_MAX)
    else $error("count above maximum");
  chk_fail_hold: assert property (power_fail [*6] |-> count_value == COUNT_RESET || $stable(count_value))
    else $error("count moved during power loss");

  // ----
  // Register bus
  // ----
  chk_b_stand: assert property (s_axil_rsp.bvalid && !s_axil_req.bready |=>
    s_axil_rsp.bvalid && $stable(s_axil_rsp.bresp))
    else $error("write response dropped");
  chk_r_stand: assert property (s_axil_rsp.rvalid && !s_axil_req.rready |=>
    s_axil_rsp.rvalid && $stable(s_axil_rsp.rdata))
    else $error("read response dropped");
  chk_r_answer: assert property (s_axil_req.arvalid && s_axil_rsp.arready |=> s_axil_rsp.rvalid)
    else $error("read answer late");

  cover property ($rose(switch_out));
  cover property (count_clear [*6]);
  cover property (power_fail [*6] ##1 count_value != COUNT_RESET);
endmodule // up_down_threshold_counter_checker

bind up_down_threshold_counter up_down_threshold_counter_checker #(
  .NUM_REFS(NUM_REFS), .CYCLE_CLOCKS(CYCLE_CLOCKS)) u_chk (.aclk, .aresetn, .s_axil_req, .s_axil_rsp,
  .count_pulse, .count_sense, .count_clear, .power_fail, .ref_values, .switch_out, .count_value);

`default_nettype wire

// *** tb/up_down_threshold_counter_tb_top.sv ***
// Self-checking bench for the threshold counter
`default_nettype none

module up_down_threshold_counter_tb_top
  import threshold_counter_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int CYC = 8;
  typedef struct packed {logic s; logic [3:0] n; logic [19:0] c; logic q;} row_t;

  logic             aclk;
  logic             aresetn;
  axil_req_t        req;
  axil_rsp_t        rsp;
  logic             pulse;
  logic             sense;
  logic             clr;
  logic             pf;
  logic [7:0][31:0] refs;
  logic             sw;
  logic [19:0]      cnt;
  int               n_mismatch;
  int               cmp_count;
  row_t             rows [5];

  up_down_threshold_counter #(.NUM_REFS(8), .CYCLE_CLOCKS(CYC)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axil_req(req), .s_axil_rsp(rsp), .count_pulse(pulse), .count_sense(sense), .count_clear(clr),
    .power_fail(pf), .ref_values(refs), .switch_out(sw), .count_value(cnt));
  pulse_source_model src (.aclk(aclk), .count_pulse(pulse));

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // ----
  // Helpers
  // ----
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tmo(input int t);
    if (t >= 100)
    begin
      n_mismatch++;
      give_verdict();
    end
  endtask

  // Address and data offered together, each dropped once taken
  // Response ready raised only after the answer shows, so the slave must hold it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge aclk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      t++;
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid && !req.bready) req.bready <= 1'b1;
    end while (!(rsp.bvalid && req.bready) && t < 100);
    tmo(t);
    check(32'(rsp.bresp), 32'(er));
    req.bready <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      t++;
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid && !req.rready) req.rready <= 1'b1;
    end while (!(rsp.rvalid && req.rready) && t < 100);
    tmo(t);
    check(rsp.rdata, e);
    check(32'(rsp.rresp), 32'(er));
    req.rready <= 1'b0;
  endtask

  // Switch is only judged after a full program cycle has passed
  task automatic step(input row_t r);
    sense <= r.s;
    @(posedge aclk);
    src.burst(int'(r.n), 2, 2);
    repeat (CYC + 6) @(posedge aclk);
    check(32'(cnt), 32'(r.c));
    check(32'(sw), 32'(r.q));
  endtask

  // ----
  // Main sequence
  // ----
  initial
  begin
    req = '0;
    sense = 1'b0;
    clr = 1'b0;
    pf = 1'b0;
    refs = '0;
    aresetn = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    rows = '{'{0, 5, 5, 0}, '{0, 1, 6, 1}, '{1, 3, 3, 1}, '{1, 1, 2, 0}, '{1, 4, 0, 0}};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) rdc(8'(4 * i), 32'h00000000, RESP_OKAY);
    rdc(8'h40, 32'h00000000, RESP_SLVERR);
    $display("reset values done");
    wr(SET_THRESH_OFS, 32'h00000006, RESP_OKAY);
    wr(CLEAR_THRESH_OFS, 32'h00000003, RESP_OKAY);
    foreach (rows[i]) step(rows[i]);
    $display("hysteresis table done");
    wr(SET_THRESH_OFS, 32'h00000003, RESP_OKAY);
    wr(CLEAR_THRESH_OFS, 32'h00000006, RESP_OKAY);
    step('{0, 3, 3, 0});
    step('{0, 1, 4, 1});
    step('{0, 2, 6, 0});
    step('{1, 2, 4, 1});
    $display("window done");
    clr <= 1'b1;
    src.burst(3, 2, 2);
    check(32'(cnt), 32'h00000000);
    check(32'(sw), 32'h00000000);
    clr <= 1'b0;
    step('{0, 3, 3, 0});
    $display("clear done");
    wr(CTRL_OFS, 32'h00000001, RESP_OKAY);
    pf <= 1'b1;
    src.burst(2, 2, 2);
    check(32'(cnt), 32'h00000003);
    rdc(STATUS_OFS, 32'h00000004, RESP_OKAY);
    pf <= 1'b0;
    wr(CTRL_OFS, 32'h00000000, RESP_OKAY);
    pf <= 1'b1;
    repeat (8) @(posedge aclk);
    check(32'(cnt), 32'h00000000);
    pf <= 1'b0;
    wr(COUNT_OFS, 32'h00000005, RESP_OKAY);
    rdc(COUNT_OFS, 32'h00000000, RESP_OKAY);
    $display("power loss done");
    refs[1] <= 32'hFFFFFFFF;
    refs[2] <= 32'h00FFFFFF;
    wr(SET_BLOCK_OFS, 32'h00000002, RESP_OKAY);
    wr(CLEAR_BLOCK_OFS, 32'h00000001, RESP_OKAY);
    wr(CTRL_OFS, 32'h00000006, RESP_OKAY);
    rdc(SET_ACTIVE_OFS, 32'h000F423F, RESP_OKAY);
    rdc(CLEAR_ACTIVE_OFS, 32'h00000000, RESP_OKAY);
    $display("referenced thresholds done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    check(32'(sw), 32'h00000000);
    aresetn <= 1'b1;
    rdc(CTRL_OFS, 32'h00000000, RESP_OKAY);
    rdc(SET_ACTIVE_OFS, 32'h00000000, RESP_OKAY);
    $display("mid-run reset done");
    give_verdict();
  end
endmodule // up_down_threshold_counter_tb_top

`default_nettype wire
